// ### hdl/i2cme_defs.svh
// Register offsets, field positions, reset values and timing counts of the I2C master
`ifndef I2CME_DEFS_SVH
`define I2CME_DEFS_SVH

`define I2CME_ADDR_DIV_LO   8'hE5
`define I2CME_ADDR_DIV_HI   8'hE6
`define I2CME_ADDR_TX       8'hE7
`define I2CME_ADDR_RX       8'hE8
`define I2CME_ADDR_CMD      8'hE9
`define I2CME_ADDR_FLAG     8'hEA
`define I2CME_ADDR_IRQ_STAT 8'hEB
`define I2CME_ADDR_IRQ_MASK 8'hEC

`define I2CME_CMD_START  7
`define I2CME_CMD_STOP   6
`define I2CME_CMD_READ   5
`define I2CME_CMD_WRITE  4
`define I2CME_CMD_NACK   3
`define I2CME_CMD_FILT   0

`define I2CME_FLG_RXACK  7
`define I2CME_FLG_BUSY   6
`define I2CME_FLG_TIP    1
`define I2CME_FLG_AL     0

`define I2CME_IRQ_DONE   0
`define I2CME_IRQ_AL     1
`define I2CME_IRQ_NOACK  2

`define I2CME_RST_BYTE   8'h00
`define I2CME_FILT_LEN   3

`endif

// ### hdl/i2cme_pkg.sv
// Types shared by the I2C master byte engine
package i2cme_pkg;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_START = 8'h02,
    ST_BIT   = 8'h04,
    ST_ACK   = 8'h08,
    ST_STOP  = 8'h10,
    ST_DONE  = 8'h20,
    ST_SPARE = 8'h40,
    ST_LOST  = 8'h80
  } i2cme_state_t;

  typedef struct packed {
    logic       start;
    logic       stop;
    logic       rd;
    logic       wr;
  } i2cme_cmd_t;

  typedef struct packed {
    logic       scl;
    logic       sda;
  } i2cme_line_t;

endpackage

// ### hdl/i2cme_sync.sv
// Two-stage synchroniser with optional filter for the bus lines that needs all three history samples to agree
`timescale 1ns/10ps
`include "i2cme_defs.svh"

module i2cme_sync (
  input  wire logic                i_clk,   // System clock
  input  wire logic                i_rst,   // Synchronous reset
  input  wire logic                i_filt,  // Noise filter enable
  input  wire i2cme_pkg::i2cme_line_t i_pin, // Raw bus levels
  output      i2cme_pkg::i2cme_line_t o_lvl  // Clean bus levels
);

  typedef struct packed {
    i2cme_pkg::i2cme_line_t                  s1;
    i2cme_pkg::i2cme_line_t                  s2;
    logic [`I2CME_FILT_LEN-1:0]              hs;
    logic [`I2CME_FILT_LEN-1:0]              hd;
    i2cme_pkg::i2cme_line_t                  lvl;
  } i2cme_sync_t;

  i2cme_sync_t r_q;
  i2cme_sync_t r_d;

  always_comb begin
    r_d    = r_q;
    r_d.s1 = i_pin;
    r_d.s2 = r_q.s1;
    r_d.hs = {r_q.hs[`I2CME_FILT_LEN-2:0], r_q.s2.scl};
    r_d.hd = {r_q.hd[`I2CME_FILT_LEN-2:0], r_q.s2.sda};
    if (!i_filt) begin
      r_d.lvl = r_q.s2;
    end else begin
      // Level changes only once the history agrees
      if (&r_q.hs) r_d.lvl.scl = 1'b1;
      else if (~|r_q.hs) r_d.lvl.scl = 1'b0;
      if (&r_q.hd) r_d.lvl.sda = 1'b1;
      else if (~|r_q.hd) r_d.lvl.sda = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_q <= '{s1: 2'b11, s2: 2'b11, hs: '1, hd: '1, lvl: 2'b11};
    end else begin
      r_q <= r_d;
    end
  end

  assign o_lvl = r_q.lvl;

endmodule

// ### hdl/i2cme_clkgen.sv
// Quarter-period tick generator driven by the prescaler
`timescale 1ns/10ps

module i2cme_clkgen (
  input  wire logic        i_clk,   // System clock
  input  wire logic        i_rst,   // Synchronous reset
  input  wire logic        i_run,   // Count while high, hold cleared otherwise
  input  wire logic [15:0] i_div,   // Prescaler value
  output      logic        o_tick   // One-cycle pulse every div+1 clocks
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } i2cme_cg_t;

  i2cme_cg_t r_q;
  i2cme_cg_t r_d;

  always_comb begin
    r_d      = r_q;
    r_d.tick = 1'b0;
    if (!i_run) begin
      r_d.cnt = 16'h0000;
    end else if (r_q.cnt >= i_div) begin
      // Quarter SCL period is div+1 clocks
      r_d.cnt  = 16'h0000;
      r_d.tick = 1'b1;
    end else begin
      r_d.cnt = r_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_tick = r_q.tick;

endmodule

// ### hdl/i2cme_top.sv
// Register-driven I2C master byte engine
`timescale 1ns/10ps
`include "i2cme_defs.svh"

// Operation
// R1: A 16-bit prescaler lives in two byte registers, low byte at the lower address, both reset to zero.
// R2: An 8-bit transmit register holds the byte the next write command shifts out.
// R3: The byte captured during a read command lands in a readable 8-bit receive register.
// R4: Command bit 7 makes a start or repeated start and then clears itself.
// R5: Command bit 6 makes a stop condition and then clears itself.
// R6: Command bit 5 reads one byte from the slave and then clears itself.
// R7: Command bit 4 shifts the transmit byte out and then clears itself.
// R8: Command bit 3 picks the master acknowledge after a read, zero for ACK and one for NACK.
// R9: The start, stop, read, write and acknowledge command bits always read as zero.
// R10: Status bit 7 shows the slave acknowledge, zero received and one not received.
// R11: Status bit 6 rises on a start seen on the bus and falls on a stop seen on the bus.
// R12: Status bit 1 is high while a byte transfer runs and drops when it completes.
// R13: Status bit 0 is set when arbitration is lost to another master.
// R14: A stop seen on the bus that this master did not request counts as arbitration loss; the code ignores such a stop while idle.
// R15: Releasing SDA high while it reads back low counts as arbitration loss; the code checks this only on the data bits of a write.
// R16: The SCL period is four times the prescaler plus one system clocks.
module i2cme_top (
  input  wire logic       i_clk,      // 40 MHz system clock
  input  wire logic       i_rst,      // Synchronous reset, active high
  input  wire logic [7:0] i_addr,     // Register address
  input  wire logic [7:0] i_wdata,    // Write data
  input  wire logic       i_wr,       // Write strobe
  input  wire logic       i_rd,       // Read strobe
  output      logic [7:0] o_rdata,    // Read data, cycle after strobe
  output      logic       o_irq,      // Level interrupt
  input  wire logic       i_scl,      // SCL pin level
  output      logic       o_scl,      // SCL output value, always 0
  output      logic       o_scl_oe,   // SCL drive low while high
  input  wire logic       i_sda,      // SDA pin level
  output      logic       o_sda,      // SDA output value, always 0
  output      logic       o_sda_oe    // SDA drive low while high
);

  typedef struct packed {
    logic [15:0]            div;
    logic [7:0]             tx;
    logic [7:0]             rx;
    i2cme_pkg::i2cme_cmd_t  cmd;
    logic                   nack;
    logic                   filt;
    logic                   rxack;
    logic                   busy;
    logic                   tip;
    logic                   al;
    logic [2:0]             ist;
    logic [2:0]             imsk;
    i2cme_pkg::i2cme_state_t st;
    logic [1:0]             ph;
    logic [2:0]             bitn;
    logic [7:0]             sh;
    logic                   is_rd;
    logic                   own_stop;
    logic                   prv_scl;
    logic                   prv_sda;
    logic                   scl_low;
    logic                   sda_low;
    logic [7:0]             rdata;
    logic                   irq;
  } i2cme_top_t;

  i2cme_top_t r_q;
  i2cme_top_t r_d;

  i2cme_pkg::i2cme_line_t pin;
  i2cme_pkg::i2cme_line_t lvl;
  logic                   tick;
  logic                   run;

  assign pin = '{scl: i_scl, sda: i_sda};
  // Divider restarts with each command so the first quarter is full length
  assign run = (r_q.st != i2cme_pkg::ST_IDLE) && (r_q.st != i2cme_pkg::ST_DONE);

  // Pins are asynchronous; three or more flops stand before any logic reads them
  i2cme_sync u_sync (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_filt (r_q.filt),
    .i_pin  (pin),
    .o_lvl  (lvl)
  );

  i2cme_clkgen u_clkgen (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_run  (run),
    .i_div  (r_q.div),   // R16
    .o_tick (tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic hit_div_lo;
  logic hit_div_hi;
  logic hit_tx;
  logic hit_rx;
  logic hit_cmd;
  logic hit_flag;
  logic hit_ist;
  logic hit_imsk;

  always_comb begin
    hit_div_lo = 1'b0;
    hit_div_hi = 1'b0;
    hit_tx     = 1'b0;
    hit_rx     = 1'b0;
    hit_cmd    = 1'b0;
    hit_flag   = 1'b0;
    hit_ist    = 1'b0;
    hit_imsk   = 1'b0;
    if (i_addr == `I2CME_ADDR_DIV_LO) hit_div_lo = 1'b1;
    else if (i_addr == `I2CME_ADDR_DIV_HI) hit_div_hi = 1'b1;
    else if (i_addr == `I2CME_ADDR_TX) hit_tx = 1'b1;
    else if (i_addr == `I2CME_ADDR_RX) hit_rx = 1'b1;
    else if (i_addr == `I2CME_ADDR_CMD) hit_cmd = 1'b1;
    else if (i_addr == `I2CME_ADDR_FLAG) hit_flag = 1'b1;
    else if (i_addr == `I2CME_ADDR_IRQ_STAT) hit_ist = 1'b1;
    else if (i_addr == `I2CME_ADDR_IRQ_MASK) hit_imsk = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus monitor on the synchronised levels

  logic start_seen;
  logic stop_seen;

  always_comb begin
    start_seen = r_q.prv_scl && lvl.scl && r_q.prv_sda && !lvl.sda;
    stop_seen  = r_q.prv_scl && lvl.scl && !r_q.prv_sda && lvl.sda;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register access and byte engine

  logic       lost;
  logic       done_ev;
  logic       noack_ev;
  logic [7:0] flag_val;

  always_comb begin
    // Spare flag bits read as zero
    flag_val   = 8'h00;
    flag_val[`I2CME_FLG_RXACK] = r_q.rxack;   // R10
    flag_val[`I2CME_FLG_BUSY]  = r_q.busy;
    flag_val[`I2CME_FLG_TIP]   = r_q.tip;
    flag_val[`I2CME_FLG_AL]    = r_q.al;
  end

  always_comb begin
    r_d         = r_q;
    lost        = 1'b0;
    done_ev     = 1'b0;
    noack_ev    = 1'b0;
    r_d.prv_scl = lvl.scl;
    r_d.prv_sda = lvl.sda;
    r_d.rdata   = 8'h00;

    // Bus busy follows what is seen on the wires
    if (start_seen) r_d.busy = 1'b1;       // R11
    else if (stop_seen) r_d.busy = 1'b0;   // R11

    // Byte engine, each tick is a quarter SCL period
    case (r_q.st)
      i2cme_pkg::ST_IDLE: begin
        if (r_q.cmd.start) begin
          r_d.st  = i2cme_pkg::ST_START;   // R4
          r_d.ph  = 2'd0;
          r_d.tip = 1'b1;
        end else if (r_q.cmd.wr || r_q.cmd.rd) begin
          r_d.st    = i2cme_pkg::ST_BIT;
          r_d.ph    = 2'd0;
          r_d.bitn  = 3'd7;
          r_d.is_rd = r_q.cmd.rd;
          r_d.sh    = r_q.cmd.rd ? 8'hFF : r_q.tx;   // R7
          r_d.tip   = 1'b1;                            // R12
        end else if (r_q.cmd.stop) begin
          r_d.st       = i2cme_pkg::ST_STOP;   // R5
          r_d.ph       = 2'd0;
          r_d.tip      = 1'b1;
          r_d.own_stop = 1'b1;
        end
      end
      i2cme_pkg::ST_START: if (tick) begin
        // Release both, then pull SDA while SCL high, then SCL low
        case (r_q.ph)
          2'd0: begin
            r_d.sda_low = 1'b0;
            r_d.scl_low = 1'b0;
          end
          2'd1: r_d.sda_low = 1'b0;
          2'd2: r_d.sda_low = 1'b1;
          default: r_d.scl_low = 1'b1;
        endcase
        r_d.ph = r_q.ph + 2'd1;
        if (r_q.ph == 2'd3) begin
          r_d.cmd.start = 1'b0;   // R4
          if (r_q.cmd.wr || r_q.cmd.rd) begin
            r_d.st    = i2cme_pkg::ST_BIT;
            r_d.bitn  = 3'd7;
            r_d.is_rd = r_q.cmd.rd;
            r_d.sh    = r_q.cmd.rd ? 8'hFF : r_q.tx;
          end else begin
            r_d.st = i2cme_pkg::ST_DONE;
          end
        end
      end
      i2cme_pkg::ST_BIT: if (tick) begin
        case (r_q.ph)
          2'd0: r_d.sda_low = !r_q.sh[7];
          2'd1: r_d.scl_low = 1'b0;
          2'd2: begin
            if (!r_q.sh[7] || lvl.sda) r_d.sh = {r_q.sh[6:0], lvl.sda};
            else r_d.sh = {r_q.sh[6:0], 1'b0};
            // Released high but read back low: another master owns the line
            if (!r_q.is_rd && r_q.sh[7] && !lvl.sda) lost = 1'b1;   // R15
          end
          default: r_d.scl_low = 1'b1;
        endcase
        r_d.ph = r_q.ph + 2'd1;
        if (r_q.ph == 2'd3) begin
          if (r_q.bitn == 3'd0) begin
            r_d.st = i2cme_pkg::ST_ACK;
          end else begin
            r_d.bitn = r_q.bitn - 3'd1;
          end
        end
      end
      i2cme_pkg::ST_ACK: if (tick) begin
        case (r_q.ph)
          2'd0: r_d.sda_low = r_q.is_rd && !r_q.nack;   // R8
          2'd1: r_d.scl_low = 1'b0;
          // On writes SDA stays released for the slave's answer
          2'd2: if (!r_q.is_rd) r_d.rxack = lvl.sda;   // R10
          default: r_d.scl_low = 1'b1;
        endcase
        r_d.ph = r_q.ph + 2'd1;
        if (r_q.ph == 2'd3) begin
          if (r_q.is_rd) r_d.rx = r_q.sh;   // R3
          else noack_ev = r_q.rxack;
          r_d.cmd.rd = 1'b0;   // R6
          r_d.cmd.wr = 1'b0;   // R7
          r_d.st     = r_q.cmd.stop ? i2cme_pkg::ST_STOP : i2cme_pkg::ST_DONE;
          r_d.own_stop = r_q.cmd.stop;
        end
      end
      i2cme_pkg::ST_STOP: if (tick) begin
        // SDA low under low SCL, then SCL up, then SDA up for the stop
        case (r_q.ph)
          2'd0: r_d.sda_low = 1'b1;
          2'd1: r_d.scl_low = 1'b0;
          2'd2: r_d.sda_low = 1'b0;
          default: r_d.cmd.stop = 1'b0;   // R5
        endcase
        r_d.ph = r_q.ph + 2'd1;
        if (r_q.ph == 2'd3) r_d.st = i2cme_pkg::ST_DONE;
      end
      // One pass here drops tip and pulses the done event
      i2cme_pkg::ST_DONE: begin
        r_d.tip      = 1'b0;   // R12
        r_d.own_stop = 1'b0;
        done_ev      = 1'b1;
        r_d.st       = i2cme_pkg::ST_IDLE;
      end
      default: r_d.st = i2cme_pkg::ST_IDLE;
    endcase

    // Stop on the wires that this master did not ask for
    // Idle is excluded: other masters may end their own frames freely
    if (stop_seen && !r_q.own_stop && r_q.st != i2cme_pkg::ST_STOP &&
        r_q.st != i2cme_pkg::ST_IDLE) lost = 1'b1;   // R14
    if (lost) begin
      r_d.al      = 1'b1;   // R13
      r_d.st      = i2cme_pkg::ST_DONE;
      r_d.sda_low = 1'b0;
      r_d.scl_low = 1'b0;
      r_d.cmd     = '0;
    end

    // Software writes; hardware clears above lose against a fresh command
    // Command bits accumulate, so a start or stop written during a byte waits its turn; a read or write is cleared with that byte
    if (i_wr) begin
      if (hit_div_lo) r_d.div[7:0] = i_wdata;   // R1
      else if (hit_div_hi) r_d.div[15:8] = i_wdata;   // R1
      else if (hit_tx) r_d.tx = i_wdata;   // R2
      else if (hit_rx) r_d.rx = i_wdata;
      else if (hit_cmd) begin
        r_d.cmd.start = r_d.cmd.start | i_wdata[`I2CME_CMD_START];
        r_d.cmd.stop  = r_d.cmd.stop  | i_wdata[`I2CME_CMD_STOP];
        r_d.cmd.rd    = r_d.cmd.rd    | i_wdata[`I2CME_CMD_READ];
        r_d.cmd.wr    = r_d.cmd.wr    | i_wdata[`I2CME_CMD_WRITE];
        r_d.nack      = i_wdata[`I2CME_CMD_NACK];   // R8
        r_d.filt      = i_wdata[`I2CME_CMD_FILT];
        if (i_wdata[`I2CME_CMD_START] | i_wdata[`I2CME_CMD_READ] |
            i_wdata[`I2CME_CMD_WRITE]) r_d.al = 1'b0;
      end
      else if (hit_ist) r_d.ist = r_q.ist & ~i_wdata[2:0];
      else if (hit_imsk) r_d.imsk = i_wdata[2:0];
    end
    // Events set after the clear so a simultaneous event survives
    if (done_ev) r_d.ist[`I2CME_IRQ_DONE] = 1'b1;
    if (lost) r_d.ist[`I2CME_IRQ_AL] = 1'b1;
    if (noack_ev) r_d.ist[`I2CME_IRQ_NOACK] = 1'b1;
    r_d.irq = |(r_d.ist & r_d.imsk);

    if (i_rd) begin
      if (hit_div_lo) r_d.rdata = r_q.div[7:0];
      else if (hit_div_hi) r_d.rdata = r_q.div[15:8];
      else if (hit_tx) r_d.rdata = r_q.tx;
      else if (hit_rx) r_d.rdata = r_q.rx;   // R3
      else if (hit_cmd) r_d.rdata = {7'h00, r_q.filt};   // R9
      else if (hit_flag) r_d.rdata = flag_val;
      else if (hit_ist) r_d.rdata = {5'h00, r_q.ist};
      else if (hit_imsk) r_d.rdata = {5'h00, r_q.imsk};
      else r_d.rdata = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_q         <= '0;
      r_q.st      <= i2cme_pkg::ST_IDLE;
      // Idle bus levels so no edge is seen just after reset
      r_q.prv_scl <= 1'b1;
      r_q.prv_sda <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_rdata  = r_q.rdata;
  assign o_irq    = r_q.irq;
  assign o_scl    = 1'b0;
  assign o_sda    = 1'b0;
  assign o_scl_oe = r_q.scl_low;
  assign o_sda_oe = r_q.sda_low;

endmodule

// ### tb/i2cme_props.sv
// Port checks of the I2C master byte engine
`timescale 1ns/10ps
module i2cme_props (
  input wire logic       i_clk,    // Clock
  input wire logic       i_rst,    // Reset
  input wire logic [7:0] i_addr,   // Address
  input wire logic [7:0] i_wdata,  // Write data
  input wire logic       i_wr,     // Write strobe
  input wire logic       i_rd,     // Read strobe
  input wire logic [7:0] o_rdata,  // Read data
  input wire logic       o_irq,    // Interrupt
  input wire logic       i_scl,    // SCL level
  input wire logic       o_scl,    // SCL value
  input wire logic       o_scl_oe, // SCL enable
  input wire logic       i_sda,    // SDA level
  input wire logic       o_sda,    // SDA value
  input wire logic       o_sda_oe  // SDA enable
);
////////////////////////////////////////////////
  logic [15:0] div_q;
  logic [17:0] lo_q;
  logic [17:0] hi_q;
  // Shadow of the prescaler, so phase lengths follow what software set
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_q <= 16'h0000;
      lo_q  <= 18'h00000;
      hi_q  <= 18'h00000;
    end else begin
      if (i_wr && i_addr == 8'hE5) div_q[7:0] <= i_wdata;
      if (i_wr && i_addr == 8'hE6) div_q[15:8] <= i_wdata;
      lo_q <= o_scl_oe ? lo_q + 18'h00001 : 18'h00000;
      hi_q <= o_scl_oe ? 18'h00000 : hi_q + 18'h00001;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_start_req; i_wr && i_addr == 8'hE9 && i_wdata[7]; endsequence
  sequence s_start_seen; $rose(o_sda_oe) && !o_scl_oe; endsequence
  sequence s_stop_req; i_wr && i_addr == 8'hE9 && i_wdata == 8'h40; endsequence
  sequence s_stop_seen; $fell(o_sda_oe) && !o_scl_oe; endsequence
  chk_start_cond: assert property (s_start_req |-> ##[1:600] s_start_seen)
    else $error("start missing");
  chk_stop_cond: assert property (s_stop_req |-> ##[1:600] s_stop_seen)
    else $error("stop missing");
  chk_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read");
  chk_cmd_reads_zero: assert property ($past(i_rd) && $past(i_addr) == 8'hE9 |-> o_rdata[7:1] == 7'h00)
    else $error("command bits read nonzero");
  chk_flag_spare: assert property ($past(i_rd) && $past(i_addr) == 8'hEA |-> o_rdata[5:2] == 4'h0)
    else $error("spare flags nonzero");
  chk_scl_low_time: assert property ($fell(o_scl_oe) |-> lo_q >= {2'b00, div_q} + 18'h00001)
    else $error("scl low phase short");
  chk_scl_high_time: assert property ($rose(o_scl_oe) |-> hi_q >= {2'b00, div_q} + 18'h00001)
    else $error("scl high phase short");
  chk_pins_open: assert property (o_scl == 1'b0 && o_sda == 1'b0)
    else $error("open drain value high");
endmodule

bind i2cme_top i2cme_props i_i2cme_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_scl(i_scl), .o_scl(o_scl),
  .o_scl_oe(o_scl_oe), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe));

// ### tb/i2cme_slave.sv
// Behavioural I2C slave: acks or refuses writes, returns a byte on reads
`timescale 1ns/10ps
module i2cme_slave (
  input  wire logic       i_scl,  // SCL level
  input  wire logic       i_sda,  // SDA level
  input  wire logic       i_nack, // Refuse written bytes
  input  wire logic [7:0] i_tx,   // Byte sent on reads
  output      logic       o_pull, // Pull SDA low
  output      logic [7:0] o_rx,   // Last byte written
  output      logic       o_mack  // Last ack bit seen
);
////////////////////////////////////////////////
  logic [3:0] n = 4'hF;
  logic [7:0] sh = 8'h00;
  logic       adr = 1'b0;
  logic       rdm = 1'b0;
  initial begin
    o_pull = 1'b0;
    o_rx = 8'h00;
    o_mack = 1'b1;
  end
  always @(negedge i_sda) if (i_scl === 1'b1) begin
    n = 4'h0;
    adr = 1'b1;
    rdm = 1'b0;
  end
  always @(posedge i_sda) if (i_scl === 1'b1) begin
    n = 4'hF;
    rdm = 1'b0;
  end
  always @(posedge i_scl) if (n < 4'h9) begin
    if (n < 4'h8) sh = {sh[6:0], i_sda};
    else o_mack = i_sda;
    n = n + 4'h1;
  end
  // Change the pull only on falling SCL edges; a refused read frees the line at once
  always @(negedge i_scl) begin
    o_pull = 1'b0;
    if (n == 4'h9) begin
      n = 4'h0;
      if (adr && sh[0]) rdm = 1'b1;
      adr = 1'b0;
      if (rdm && o_mack) n = 4'hF;
    end
    if (rdm && n < 4'h8) o_pull = ~i_tx[7 - n];
    else if (!rdm && n == 4'h8) begin
      o_rx = sh;
      o_pull = ~i_nack;
    end
  end
endmodule

// ### tb/tb_i2c_master_byte_engine.sv
// Self-checking bench of the I2C master byte engine
`timescale 1ns/10ps
module tb_i2c_master_byte_engine;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, s_tx = 8'hA5, s_rx;
  logic       scl_oe, sda_oe, pull, other = 1'b0, nack = 1'b0, irq, scl, sda, mack;
  int         errors = 0, n_compared = 0, cyc = 0;
  assign scl = ~scl_oe;
  assign sda = ~sda_oe & ~pull & ~other;  // Pull-up when all release
  always #12.5 clk = ~clk;
  i2cme_top i_i2cme_top (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_scl(scl), .o_scl(),
    .o_scl_oe(scl_oe), .i_sda(sda), .o_sda(), .o_sda_oe(sda_oe));
  i2cme_slave i_i2cme_slave (.i_scl(scl), .i_sda(sda), .i_nack(nack), .i_tx(s_tx),
    .o_pull(pull), .o_rx(s_rx), .o_mack(mack));
////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rreg(a, d);
    check(d, e);
  endtask
  // Bounded poll until a flag bit drops
  task automatic wait_clr(input int b);
    logic [7:0] f;
    f = 8'hFF;
    for (int k = 0; k < 200 && f[b] !== 1'b0; k++) rreg(8'hEA, f);
  endtask
  task automatic irq_after(input logic e);
    repeat (2) @(posedge clk);
    #1 check(irq, e);
  endtask
////////////////////////////////////////////////
  task automatic t_regs;
    for (int k = 0; k < 8; k++) rchk(8'hE5 + k[7:0], 8'h00);
    wreg(8'hE5, 8'h5A);
    wreg(8'hE6, 8'hC3);
    wreg(8'hE7, 8'h3C);
    wreg(8'hE4, 8'hFF);
    wreg(8'hE9, 8'h09);
    rchk(8'hE5, 8'h5A);
    rchk(8'hE6, 8'hC3);
    rchk(8'hE7, 8'h3C);
    rchk(8'hE4, 8'h00);
    rchk(8'hE9, 8'h01);
    wreg(8'hE9, 8'h00);
    wreg(8'hE5, 8'h02);
    wreg(8'hE6, 8'h00);
    wreg(8'hEC, 8'h07);
  endtask
  task automatic t_write;
    logic [7:0] f;
    time        t;
    wreg(8'hE7, 8'hA4);
    wreg(8'hE9, 8'h90);
    rreg(8'hEA, f);
    check(f[1], 1'b1);
    @(posedge scl);
    t = $time;
    @(posedge scl);
    check(16'(($time - t) / 25), 16'h000C);
    wait_clr(1);
    check(s_rx, 8'hA4);
    rchk(8'hEA, 8'h40);
    check(irq, 1'b1);
    rchk(8'hEB, 8'h01);
    wreg(8'hEB, 8'h01);
    irq_after(1'b0);
  endtask
  task automatic t_read;
    logic [7:0] f;
    nack = 1'b1;
    wreg(8'hEC, 8'h00);
    wreg(8'hE7, 8'h55);
    wreg(8'hE9, 8'h10);
    wait_clr(1);
    rchk(8'hEA, 8'hC0);
    rchk(8'hEB, 8'h05);
    check(irq, 1'b0);
    wreg(8'hEC, 8'h04);
    irq_after(1'b1);
    wreg(8'hEB, 8'h07);
    irq_after(1'b0);
    nack = 1'b0;
    wreg(8'hE7, 8'h91);
    wreg(8'hE9, 8'h90);
    wait_clr(1);
    wreg(8'hE9, 8'h20);
    wait_clr(1);
    rchk(8'hE8, 8'hA5);
    check(mack, 1'b0);
    s_tx = 8'hC3;
    wreg(8'hE9, 8'h28);
    wait_clr(1);
    rchk(8'hE8, 8'hC3);
    check(mack, 1'b1);
    wreg(8'hE9, 8'h40);
    wait_clr(6);
    rreg(8'hEA, f);
    check(f[6], 1'b0);
  endtask
  // Second master holds SDA low while this one sends ones
  task automatic t_arb;
    logic [7:0] f;
    wreg(8'hE7, 8'hFF);
    wreg(8'hE9, 8'h90);
    @(posedge scl_oe);
    @(posedge clk);
    other <= 1'b1;
    wait_clr(1);
    rreg(8'hEA, f);
    check(f[0], 1'b1);
    rreg(8'hEB, f);
    check(f[1], 1'b1);
    @(posedge clk);
    other <= 1'b0;
  endtask
  // Second master ends the frame with a stop during the acknowledge bit
  task automatic t_stop_lost;
    logic [7:0] f;
    nack = 1'b1;
    wreg(8'hEB, 8'h07);
    wreg(8'hE7, 8'h00);
    wreg(8'hE9, 8'h90);
    rreg(8'hEA, f);
    check(f[0], 1'b0);
    repeat (8) @(posedge scl);
    @(negedge scl);
    @(posedge clk);
    other <= 1'b1;
    @(posedge scl);
    @(posedge clk);
    other <= 1'b0;
    wait_clr(1);
    rreg(8'hEA, f);
    check(f[0], 1'b1);
    check(f[6], 1'b0);
    rreg(8'hEB, f);
    check(f[1], 1'b1);
  endtask
////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      test_done;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_write;
    t_read;
    t_arb;
    t_stop_lost;
    test_done;
  end
endmodule
